// file: src/dtc_pkg.sv
package dtc_pkg;
    // Register addresses on the special-register port
    localparam logic [7:0] ADDR_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_UNIT0_LOW = 8'h8A;
    localparam logic [7:0] ADDR_UNIT1_LOW = 8'h8B;
    localparam logic [7:0] ADDR_UNIT0_HIGH = 8'h8C;
    localparam logic [7:0] ADDR_UNIT1_HIGH = 8'h8D;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_FULL = 8'hFF;
    localparam logic [4:0] PRESCALE_FULL = 5'h1F;
    // Field positions inside the mode register, per unit nibble
    localparam int UNIT_NIBBLE = 4;
    localparam int GATE_BIT = 3;
    localparam int SELECT_BIT = 2;
    localparam int MODE_UPPER_BIT = 1;
    localparam int MODE_LOWER_BIT = 0;
    // Control register bit positions
    localparam int FLAG1_BIT = 7;
    localparam int RUN1_BIT = 6;
    localparam int FLAG0_BIT = 5;
    localparam int RUN0_BIT = 4;
    // Machine cycle: 12 core clocks, phase index = (state-1)*2 + (phase-1)
    localparam logic [3:0] CLOCKS_PER_MACHINE = 4'hC;
    localparam logic [3:0] PHASE_LAST = 4'hB;
    localparam logic [3:0] SAMPLE_PHASE = 4'h9;
    localparam logic [3:0] UPDATE_PHASE = 4'h4;
    localparam logic [3:0] PHASE_ZERO = 4'h0;
    localparam logic [3:0] PHASE_ONE = 4'h1;
    // Mode field encodings
    localparam logic [1:0] MODE_PRESCALED = 2'h0;
    localparam logic [1:0] MODE_FULL16 = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    typedef struct packed {
        logic ovf;
        logic [7:0] hi;
        logic [7:0] lo;
    } dtc_step_type;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dtc_sfr_type;
endpackage : dtc_pkg

// file: src/dtc_timer_pair.sv
`timescale 1ns/100ps
// Summary of operation
// - Timer function advances the low byte once per twelve-clock machine cycle.
// - Counter function samples the count pin at sample_phase, counts high-then-low.
// - A detected fall shows in the count at update_phase of the next cycle.
// - Recognising one fall takes two machine cycles, limiting external rate.
// - Gating bit set: count only while gate pin high and run bit set.
// - Select bit set counts pin falls; clear counts machine cycles.
// - Mode field is bits 5:4 for unit 1, bits 1:0 for unit 0.
// - Mode 00: high byte counts, low byte five bits form a prescaler.
// - Mode 01: high and low bytes cascade into one 16-bit counter.
// - Mode 10: low byte counts, reloads from high byte on overflow.
// - Mode 11 on unit 1 stops unit 1 counting.
// - Mode 11 on unit 0 splits it into two independent 8-bit counters.
// - Each unit consists of one high byte and one low byte register.
// - Overflow sets the flag; vectoring clears it; software drives run bits.
// - In mode 00 the upper three low-byte bits are left untouched.
// - Split unit 0 high byte counts cycles using unit 1 run and flag.
module dtc_timer_pair (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire dtc_pkg::dtc_sfr_type sfr_i,
    input wire logic [1:0] vector_ack_i,
    input wire logic unit0_count_pin_i,
    input wire logic unit1_count_pin_i,
    input wire logic unit0_gate_pin_i,
    input wire logic unit1_gate_pin_i,
    output logic [7:0] sfr_rdata_o,
    output logic unit0_overflow_flag_o,
    output logic unit1_overflow_flag_o
);
    import dtc_pkg::*;

    function automatic dtc_step_type step(input logic [1:0] mode, input logic [7:0] hi,
                                          input logic [7:0] lo);
        dtc_step_type r;
        r = '{ovf: 1'b0, hi: hi, lo: lo};
        case (mode)
            MODE_PRESCALED: begin
                r.lo[4:0] = lo[4:0] + 5'h1;
                if (lo[4:0] == PRESCALE_FULL) begin
                    r.hi = hi + 8'h01;
                    r.ovf = (hi == BYTE_FULL);
                end
            end
            MODE_FULL16: begin
                {r.ovf, r.hi, r.lo} = {1'b0, hi, lo} + 17'h0_0001;
            end
            MODE_RELOAD: begin
                r.ovf = (lo == BYTE_FULL);
                r.lo = r.ovf ? hi : lo + 8'h01;
            end
            default: begin
                r.ovf = (lo == BYTE_FULL);
                r.lo = lo + 8'h01;
            end
        endcase
        return r;
    endfunction : step

    logic [3:0] phase_q, phase_d;
    logic [3:0][2:0] sync_q, sync_d;
    logic [3:0] filt_q, filt_d;
    logic [1:0] samp_q, samp_d, pend_q, pend_d;
    logic [7:0] mode_q, mode_d;
    logic [1:0] run_q, run_d, flag_q, flag_d;
    logic [1:0][7:0] hi_q, hi_d, lo_q, lo_d;
    logic [7:0] rdata_q, rdata_d;
    logic [1:0] tick, en, gate, sel, hw_set;
    logic [1:0][1:0] mode_f;
    logic split0, tick0_high;
    dtc_step_type res0, res1, res0_high;
    logic [3:0] pins;

    assign pins = {unit1_gate_pin_i, unit0_gate_pin_i, unit1_count_pin_i, unit0_count_pin_i};

    // Three-stage synchronisers; first stage feeds only the second
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_comb begin
                sync_d[gi] = {sync_q[gi][1:0], pins[gi]};
                filt_d[gi] = (sync_q[gi][1] == sync_q[gi][2]) ? sync_q[gi][2] : filt_q[gi];
            end
        end
        for (gi = 0; gi < 2; gi++) begin : g_ctl
            assign gate[gi] = mode_q[gi*UNIT_NIBBLE + GATE_BIT];
            assign sel[gi] = mode_q[gi*UNIT_NIBBLE + SELECT_BIT];
            assign mode_f[gi] = {mode_q[gi*UNIT_NIBBLE + MODE_UPPER_BIT],
                                 mode_q[gi*UNIT_NIBBLE + MODE_LOWER_BIT]};
            assign en[gi] = run_q[gi] & (~gate[gi] | filt_q[2 + gi]);
            // Timer ticks once per machine cycle; counter ticks on a pending fall
            assign tick[gi] = (phase_q == UPDATE_PHASE) & en[gi]
                              & (sel[gi] ? pend_q[gi] : 1'b1);
        end
    endgenerate

    assign split0 = (mode_f[0] == MODE_SPLIT);
    assign tick0_high = split0 & (phase_q == UPDATE_PHASE) & run_q[1];
    assign res0 = step(mode_f[0], hi_q[0], lo_q[0]);
    assign res1 = step(mode_f[1], hi_q[1], lo_q[1]);
    assign res0_high = step(MODE_SPLIT, BYTE_ZERO, hi_q[0]);
    assign hw_set[0] = tick[0] & res0.ovf;
    // Split unit 0 takes over unit 1's flag; unit 1 then counts silently
    assign hw_set[1] = split0 ? (tick0_high & res0_high.ovf)
                              : (tick[1] & res1.ovf & (mode_f[1] != MODE_SPLIT));

    always_comb begin
        phase_d = (phase_q == PHASE_LAST) ? PHASE_ZERO : phase_q + PHASE_ONE;
        samp_d = samp_q;
        pend_d = pend_q;
        if (phase_q == UPDATE_PHASE) begin
            pend_d = 2'h0;
        end
        // Two samples a machine cycle apart are needed per fall, hence the rate limit
        if (phase_q == SAMPLE_PHASE) begin
            samp_d = filt_q[1:0];
            pend_d = samp_q & ~filt_q[1:0];
        end
        mode_d = mode_q;
        run_d = run_q;
        hi_d = hi_q;
        lo_d = lo_q;
        flag_d = flag_q & ~vector_ack_i;
        if (tick[0]) begin
            lo_d[0] = res0.lo;
            if (!split0) begin
                hi_d[0] = res0.hi;
            end
        end
        if (tick0_high) begin
            hi_d[0] = res0_high.lo;
        end
        if (tick[1] && mode_f[1] != MODE_SPLIT) begin
            hi_d[1] = res1.hi;
            lo_d[1] = res1.lo;
        end
        if (sfr_i.wr) begin
            case (sfr_i.addr)
                ADDR_MODE: mode_d = sfr_i.wdata;
                ADDR_UNIT0_LOW: lo_d[0] = sfr_i.wdata;
                ADDR_UNIT1_LOW: lo_d[1] = sfr_i.wdata;
                ADDR_UNIT0_HIGH: hi_d[0] = sfr_i.wdata;
                ADDR_UNIT1_HIGH: hi_d[1] = sfr_i.wdata;
                ADDR_CONTROL: begin
                    run_d = {sfr_i.wdata[RUN1_BIT], sfr_i.wdata[RUN0_BIT]};
                    flag_d = {sfr_i.wdata[FLAG1_BIT], sfr_i.wdata[FLAG0_BIT]};
                end
                default: ;
            endcase
        end
        // Hardware set wins over any clear in the same cycle
        flag_d = flag_d | hw_set;
        case (sfr_i.addr)
            ADDR_MODE: rdata_d = mode_q;
            ADDR_UNIT0_LOW: rdata_d = lo_q[0];
            ADDR_UNIT1_LOW: rdata_d = lo_q[1];
            ADDR_UNIT0_HIGH: rdata_d = hi_q[0];
            ADDR_UNIT1_HIGH: rdata_d = hi_q[1];
            ADDR_CONTROL: rdata_d = {flag_q[1], run_q[1], flag_q[0], run_q[0], 4'h0};
            default: rdata_d = BYTE_ZERO;
        endcase
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_q <= PHASE_ZERO;
            sync_q <= '0;
            filt_q <= '0;
            samp_q <= '0;
            pend_q <= '0;
            mode_q <= MODE_RESET;
            run_q <= '0;
            flag_q <= '0;
            hi_q <= '0;
            lo_q <= '0;
            rdata_q <= BYTE_ZERO;
        end else begin
            phase_q <= phase_d;
            sync_q <= sync_d;
            filt_q <= filt_d;
            samp_q <= samp_d;
            pend_q <= pend_d;
            mode_q <= mode_d;
            run_q <= run_d;
            flag_q <= flag_d;
            hi_q <= hi_d;
            lo_q <= lo_d;
            rdata_q <= rdata_d;
        end
    end

    assign sfr_rdata_o = rdata_q;
    assign unit0_overflow_flag_o = flag_q[0];
    assign unit1_overflow_flag_o = flag_q[1];

    // Helper terms for the checks below
    logic wr_lo0, wr_hi0, wr_u1;
    assign wr_lo0 = sfr_i.wr & (sfr_i.addr == ADDR_UNIT0_LOW);
    assign wr_hi0 = sfr_i.wr & (sfr_i.addr == ADDR_UNIT0_HIGH);
    assign wr_u1 = sfr_i.wr & ((sfr_i.addr == ADDR_UNIT1_LOW) | (sfr_i.addr == ADDR_UNIT1_HIGH));

    AST_PHASE_WRAP: assert property (@(posedge clock_i) disable iff (!rstn_i)
        phase_q == PHASE_LAST |=> phase_q == PHASE_ZERO ##11 phase_q == PHASE_LAST)
        else $error("Machine cycle is not twelve clocks");
    AST_LOW_AT_UPDATE: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (phase_q != UPDATE_PHASE && !wr_lo0) |=> $stable(lo_q[0]))
        else $error("Unit 0 low byte moved outside the update phase");
    AST_FULL16_STEP: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (mode_f[0] == MODE_FULL16 && !sel[0] && en[0] && phase_q == UPDATE_PHASE
         && !wr_lo0 && !wr_hi0)
        |=> {hi_q[0], lo_q[0]} == $past({hi_q[0], lo_q[0]}) + 16'h0001)
        else $error("16-bit count did not advance by one");
    AST_UNIT1_STOP: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (mode_f[1] == MODE_SPLIT && !wr_u1) |=> $stable({hi_q[1], lo_q[1]}))
        else $error("Unit 1 counted in its stop mode");
    AST_GATE_HOLD: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (gate[0] && !filt_q[2] && !wr_lo0) |=> $stable(lo_q[0]))
        else $error("Gated unit 0 counted with gate pin low");
    AST_RELOAD: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (mode_f[0] == MODE_RELOAD && tick[0] && lo_q[0] == BYTE_FULL && !wr_lo0 && !wr_hi0)
        |=> lo_q[0] == hi_q[0] && flag_q[0])
        else $error("Reload or flag missing on low byte overflow");
    AST_PRESCALE_TOP: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (mode_f[0] == MODE_PRESCALED && !wr_lo0) |=> $stable(lo_q[0][7:5]))
        else $error("Prescaler touched the upper low-byte bits");
    AST_COUNT_FALL: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (phase_q == SAMPLE_PHASE && samp_q[0] && !filt_q[0])
        |-> ##7 (phase_q == UPDATE_PHASE && pend_q[0]))
        else $error("Detected fall not pending at the update phase");
    AST_FLAG_WINS: assert property (@(posedge clock_i) disable iff (!rstn_i)
        hw_set[0] |=> flag_q[0])
        else $error("Overflow flag lost against a clear");
endmodule : dtc_timer_pair

// file: testbench/dtc_pin_model.sv
`timescale 1ns/100ps
module dtc_pin_model (
    input wire logic clock_i,
    output logic [1:0] count_pin_o,
    output logic [1:0] gate_pin_o
);
    initial begin
        count_pin_o = 2'h3;
        gate_pin_o = 2'h0;
    end
    // Levels held 16 clocks, above one machine cycle so none is missed
    task automatic falls(input int unit, input int n);
        repeat (n) begin
            repeat (16) @(posedge clock_i);
            count_pin_o[unit] <= 1'b0;
            repeat (16) @(posedge clock_i);
            count_pin_o[unit] <= 1'b1;
        end
    endtask : falls
    task automatic set_gate(input int unit, input logic v);
        @(posedge clock_i);
        gate_pin_o[unit] <= v;
    endtask : set_gate
endmodule : dtc_pin_model

// file: testbench/tb.sv
`timescale 1ns/100ps
module tb;
    import dtc_pkg::*;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    dtc_sfr_type sfr = '0;
    logic [1:0] ack = 2'h0;
    logic [1:0] cpin;
    logic [1:0] gpin;
    logic [7:0] rdata;
    logic flag0;
    logic flag1;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    dtc_timer_pair dut_u (.clock_i(clock_i), .rstn_i(rstn_i), .sfr_i(sfr),
        .vector_ack_i(ack), .unit0_count_pin_i(cpin[0]), .unit1_count_pin_i(cpin[1]),
        .unit0_gate_pin_i(gpin[0]), .unit1_gate_pin_i(gpin[1]), .sfr_rdata_o(rdata),
        .unit0_overflow_flag_o(flag0), .unit1_overflow_flag_o(flag1));
    dtc_pin_model pm (.clock_i(clock_i), .count_pin_o(cpin), .gate_pin_o(gpin));
    initial forever #12.5 clock_i = ~clock_i;
    // Whole run needs well under 2000 cycles
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (bad_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        sfr <= '{wr: 1'b1, addr: a, wdata: d};
        @(posedge clock_i);
        sfr.wr <= 1'b0;
    endtask : wr
    task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        sfr.addr <= a;
        @(posedge clock_i);
        #1 chk(name, rdata, exp);
    endtask : rchk
    task automatic setup(input logic [7:0] mode, input logic [7:0] la, input logic [7:0] lo,
                         input logic [7:0] ha, input logic [7:0] hi);
        wr(ADDR_MODE, mode);
        wr(la, lo);
        wr(ha, hi);
    endtask : setup
    // Run exactly n machine cycles; overflow is placed on the first tick
    task automatic run_for(input logic [7:0] ctrl, input int n, input logic [1:0] fl);
        wr(ADDR_CONTROL, ctrl);
        repeat (12 * n - 2) @(posedge clock_i);
        #1 chk("flags", {6'h00, flag1, flag0}, {6'h00, fl});
        wr(ADDR_CONTROL, 8'h00);
    endtask : run_for
    task automatic t_reset();
        rchk("mode", ADDR_MODE, 8'h00);
        rchk("control", ADDR_CONTROL, 8'h00);
        rchk("unmapped", 8'h90, 8'h00);
    endtask : t_reset
    task automatic t_modes();
        setup(8'h01, ADDR_UNIT0_LOW, 8'hFF, ADDR_UNIT0_HIGH, 8'hFF);
        rchk("mode rb", ADDR_MODE, 8'h01);
        run_for(8'h10, 2, 2'b01);
        rchk("m1 lo", ADDR_UNIT0_LOW, 8'h01);
        rchk("m1 hi", ADDR_UNIT0_HIGH, 8'h00);
        setup(8'h00, ADDR_UNIT0_LOW, 8'hFF, ADDR_UNIT0_HIGH, 8'h00);
        run_for(8'h10, 2, 2'b00);
        rchk("m0 lo", ADDR_UNIT0_LOW, 8'hE1);
        rchk("m0 hi", ADDR_UNIT0_HIGH, 8'h01);
        setup(8'h02, ADDR_UNIT0_LOW, 8'hFF, ADDR_UNIT0_HIGH, 8'h80);
        run_for(8'h10, 2, 2'b01);
        rchk("m2 lo", ADDR_UNIT0_LOW, 8'h81);
        rchk("m2 hi", ADDR_UNIT0_HIGH, 8'h80);
    endtask : t_modes
    task automatic t_unit1();
        setup(8'h10, ADDR_UNIT1_LOW, 8'hFF, ADDR_UNIT1_HIGH, 8'hFF);
        run_for(8'h40, 2, 2'b10);
        rchk("u1 lo", ADDR_UNIT1_LOW, 8'h01);
        wr(ADDR_MODE, 8'h30);
        run_for(8'h40, 2, 2'b00);
        rchk("u1 stop", ADDR_UNIT1_LOW, 8'h01);
    endtask : t_unit1
    task automatic t_split();
        setup(8'h03, ADDR_UNIT0_LOW, 8'h10, ADDR_UNIT0_HIGH, 8'hFF);
        run_for(8'h50, 2, 2'b10);
        rchk("split lo", ADDR_UNIT0_LOW, 8'h12);
        rchk("split hi", ADDR_UNIT0_HIGH, 8'h01);
    endtask : t_split
    task automatic t_gate();
        setup(8'h09, ADDR_UNIT0_LOW, 8'h00, ADDR_UNIT0_HIGH, 8'h00);
        run_for(8'h10, 2, 2'b00);
        rchk("gated", ADDR_UNIT0_LOW, 8'h00);
        pm.set_gate(0, 1'b1);
        run_for(8'h10, 2, 2'b00);
        rchk("gate open", ADDR_UNIT0_LOW, 8'h02);
    endtask : t_gate
    task automatic t_ack();
        setup(8'h01, ADDR_UNIT0_LOW, 8'hFF, ADDR_UNIT0_HIGH, 8'hFF);
        wr(ADDR_CONTROL, 8'h10);
        repeat (14) @(posedge clock_i);
        #1 chk("flag set", {7'h00, flag0}, 8'h01);
        @(posedge clock_i);
        ack <= 2'b01;
        @(posedge clock_i);
        ack <= 2'b00;
        #1 chk("flag ack", {7'h00, flag0}, 8'h00);
        wr(ADDR_CONTROL, 8'h00);
    endtask : t_ack
    task automatic t_count();
        setup(8'h05, ADDR_UNIT0_LOW, 8'h00, ADDR_UNIT0_HIGH, 8'h00);
        wr(ADDR_CONTROL, 8'h10);
        pm.falls(0, 3);
        repeat (36) @(posedge clock_i);
        wr(ADDR_CONTROL, 8'h00);
        rchk("falls", ADDR_UNIT0_LOW, 8'h03);
    endtask : t_count
    // Unit 1 as a gated pin counter, then with its gate pin closed
    task automatic t_pins1();
        setup(8'hD0, ADDR_UNIT1_LOW, 8'h00, ADDR_UNIT1_HIGH, 8'h00);
        pm.set_gate(1, 1'b1);
        wr(ADDR_CONTROL, 8'h40);
        pm.falls(1, 2);
        repeat (36) @(posedge clock_i);
        wr(ADDR_CONTROL, 8'h00);
        rchk("u1 falls", ADDR_UNIT1_LOW, 8'h02);
        rchk("u1 falls hi", ADDR_UNIT1_HIGH, 8'h00);
        pm.set_gate(1, 1'b0);
        wr(ADDR_CONTROL, 8'h40);
        pm.falls(1, 1);
        repeat (36) @(posedge clock_i);
        wr(ADDR_CONTROL, 8'h00);
        rchk("u1 gate shut", ADDR_UNIT1_LOW, 8'h02);
    endtask : t_pins1
    initial begin
        repeat (10) @(posedge clock_i);
        rstn_i <= 1'b1;
        t_reset();
        t_modes();
        t_unit1();
        t_split();
        t_gate();
        t_ack();
        t_count();
        t_pins1();
        tally_and_finish();
    end
endmodule : tb
